// *** inc/mmad_defs.vh ***
/*
 Constants of the memory map and address decode block: SFR offsets, field
 positions, reset values and region limits. Assumes an 8-bit core with a
 16-bit program counter and an 8-bit SFR space above 80h.
*/
// Behaviour
// RL1: Fetch beyond main flash returns NOP until 3fff, then wraps to 0000.
// RL2: Boot select zero starts fetching main flash at 0000 after reset.
// RL3: Loader flash of 2 KB is remapped to address zero when executing it.
// RL4: Data flash start is base register high byte with low byte 00.
// RL5: Every reset reloads the base register from its configuration byte.
// RL6: Main flash ends where data flash begins; the two share 16 KB.
// RL7: Base register writes need the timed access unlock sequence.
// RL8: Base register applies only while config byte zero bit 0 is zero.
// RL9: 256-byte auxiliary RAM at 00 to ff via external moves only.
// RL10: Software never places the stack in auxiliary RAM.
// RL11: SFRs decode on direct access only; scratch RAM on direct and indirect.
// RL12: Aux function bit 0 selects standard or second data pointer.
// RL13: Aux function register resets to zero; bit 1 reads zero.
// RL14: Power control bits 3 and 2 are free user flags.
// RL15: Program memory is readable as data by code-space moves.
// RL16: Unlocked-less writes to the base register are discarded.
`ifndef MMAD_DEFS_VH
`define MMAD_DEFS_VH
`define MMAD_PWRCTL_ADDR   8'h87
`define MMAD_AUXFN_ADDR    8'ha2
`define MMAD_UNLK_ADDR     8'hc7
`define MMAD_DFBASE_ADDR   8'he1
`define MMAD_PWRCTL_RST    8'h00
`define MMAD_AUXFN_RST     8'h00
`define MMAD_AUXFN_MASK    8'hfd
`define MMAD_DFBASE_RST    8'h00
`define MMAD_PTRSEL_BIT    0
`define MMAD_DFOFF_BIT     0
`define MMAD_PROG_TOP      16'h3fff
`define MMAD_PROG_START    16'h0000
`define MMAD_LDR_TOP       16'h07ff
`define MMAD_NOP_OP        8'h00
`define MMAD_UNLK_KEY1     8'haa
`define MMAD_UNLK_KEY2     8'h55
`define MMAD_UNLK_WINDOW   3'd4
`define MMAD_SFR_FLOOR     8'h80
`endif

// *** rtl/mmad_ta_gate.v ***
/*
 Timed access gate: opens a short write window after the two-byte key.
 Assumes writes to the unlock address arrive as single-cycle strobes.
*/
`timescale 1ns/1ps
`include "mmad_defs.vh"
module mmad_unlock_gate (
   // Clock and reset
   input  wire       clk_i,
   input  wire       sys_rst_i,
   // Unlock port
   input  wire       key_wr_i,
   input  wire [7:0] key_data_i,
   input  wire       consume_i,
   output wire       open_o
);
   reg       half_ff;
   reg [2:0] win_ff;
   reg       nxt_half;
   reg [2:0] nxt_win;
   always @* begin
      nxt_half = 1'b0;
      nxt_win  = (win_ff != 3'd0) ? win_ff - 3'd1 : 3'd0;
      if (consume_i) begin
         nxt_win = 3'd0;
      end
      // Window closes itself so a stray later write stays protected
      if (key_wr_i) begin
         if (key_data_i == `MMAD_UNLK_KEY1) begin
            nxt_half = 1'b1;
         end else if (half_ff && key_data_i == `MMAD_UNLK_KEY2) begin
            nxt_win = `MMAD_UNLK_WINDOW; // RL7
         end
      end else begin
         nxt_half = half_ff && (win_ff == 3'd0);
      end
   end
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         half_ff <= 1'b0;
         win_ff  <= 3'd0;
      end else begin
         half_ff <= nxt_half;
         win_ff  <= nxt_win;
      end
   end
   assign open_o = (win_ff != 3'd0);
endmodule // mmad_unlock_gate

// *** rtl/mmad_decode.v ***
/*
 Memory map and address decode: program fetch steering with NOP fill and
 wrap, loader remap, movable data flash boundary, auxiliary RAM, scratch RAM
 with direct-only SFR decode, data pointer select, user flags.
 Assumes the core issues one access per cycle; data reads answer one edge
 later, fetch and code reads two, as the outside arrays answer flash_addr_o.
*/
`timescale 1ns/1ps
`include "mmad_defs.vh"
module mmad_decode #(
   parameter AUX_DEPTH = 256,
   parameter RAM_DEPTH = 256
) (
   // Clock and reset
   input  wire        clk_i,
   input  wire        sys_rst_i,
   // Configuration bytes
   input  wire        boot_select_i,
   input  wire [7:0]  config_byte_zero_i,
   input  wire [7:0]  config_data_flash_base_i,
   // Instruction fetch
   input  wire        fetch_req_i,
   input  wire [15:0] fetch_pc_i,
   output reg  [7:0]  fetch_data_o,
   output reg  [15:0] next_pc_o,
   // Code-space data read
   input  wire        code_rd_i,
   input  wire [15:0] code_addr_i,
   output reg  [7:0]  code_data_o,
   // Flash arrays
   output reg  [15:0] flash_addr_o,
   output reg         flash_ldr_sel_o,
   input  wire [7:0]  flash_data_i,
   input  wire [7:0]  ldr_data_i,
   // Internal data space
   input  wire        idata_rd_i,
   input  wire        idata_wr_i,
   input  wire        idata_direct_i,
   input  wire [7:0]  idata_addr_i,
   input  wire [7:0]  idata_wdata_i,
   output reg  [7:0]  idata_rdata_o,
   output reg         sfr_sel_o,
   // External move space
   input  wire        xmove_rd_i,
   input  wire        xmove_wr_i,
   input  wire [15:0] xmove_addr_i,
   input  wire [7:0]  xmove_wdata_i,
   output reg  [7:0]  xmove_rdata_o,
   // Status
   output reg         data_pointer_select_o,
   output reg  [15:0] data_flash_start_o,
   output reg  [15:0] main_program_flash_top_o
);
   reg  [7:0]  aux_ram_ff [0:AUX_DEPTH-1];
   reg  [7:0]  ram_ff     [0:RAM_DEPTH-1];
   reg  [7:0]  pwr_ctrl_ff;
   reg  [7:0]  aux_func_ff;
   reg  [7:0]  data_flash_base_high_ff;
   reg         ldr_run_ff;
   reg         ldr_pend_ff;
   reg  [7:0]  nxt_rdata;
   reg         nxt_sfr;
   reg  [15:0] nxt_df_start;
   reg  [15:0] nxt_pc;
   reg  [7:0]  nxt_fetch;
   reg         nxt_nop;
   reg         fetch_pend_ff;
   reg         fetch_nop_ff;
   reg         code_pend_ff;
   wire        unlock_open;
   wire        sfr_acc;
   wire        base_wr;
   wire        key_wr;
   wire        df_active;
   wire        past_main;
   integer     i;

   // Direct access above 80h reaches SFRs; indirect always reaches RAM
   assign sfr_acc   = idata_direct_i && (idata_addr_i >= `MMAD_SFR_FLOOR); // RL11
   assign key_wr    = idata_wr_i && sfr_acc && (idata_addr_i == `MMAD_UNLK_ADDR);
   assign base_wr   = idata_wr_i && sfr_acc && (idata_addr_i == `MMAD_DFBASE_ADDR);
   assign df_active = ~config_byte_zero_i[`MMAD_DFOFF_BIT]; // RL8

   mmad_unlock_gate u_unlock (
      .clk_i      (clk_i),
      .sys_rst_i  (sys_rst_i),
      .key_wr_i   (key_wr),
      .key_data_i (idata_wdata_i),
      .consume_i  (base_wr),
      .open_o     (unlock_open)
   );

   always @* begin
      if (df_active) begin
         nxt_df_start = {data_flash_base_high_ff, 8'h00}; // RL4
      end else begin
         nxt_df_start = `MMAD_PROG_TOP + 16'h0001;
      end
   end
   // Main flash stops where data flash begins
   assign past_main = (fetch_pc_i >= nxt_df_start) || (fetch_pc_i > `MMAD_PROG_TOP); // RL6

   always @* begin
      nxt_pc    = fetch_pc_i + 16'h0001;
      nxt_nop   = 1'b0;
      // The registered select already names the array that answers now
      nxt_fetch = flash_ldr_sel_o ? ldr_data_i : flash_data_i;
      if (ldr_run_ff) begin
         if (fetch_pc_i >= `MMAD_LDR_TOP) begin
            nxt_pc = `MMAD_PROG_START;
         end
      end else begin
         if (past_main) begin
            nxt_nop = 1'b1; // RL1
         end
         if (fetch_pc_i >= `MMAD_PROG_TOP) begin
            nxt_pc = `MMAD_PROG_START; // RL1
         end
      end
   end

   always @* begin
      nxt_rdata = 8'h00;
      nxt_sfr   = sfr_acc;
      if (!sfr_acc) begin
         nxt_rdata = ram_ff[idata_addr_i[7:0]]; // RL11
      end else begin
         case (idata_addr_i)
            `MMAD_PWRCTL_ADDR: nxt_rdata = pwr_ctrl_ff;
            `MMAD_AUXFN_ADDR:  nxt_rdata = aux_func_ff & `MMAD_AUXFN_MASK; // RL13
            `MMAD_DFBASE_ADDR: nxt_rdata = data_flash_base_high_ff;
            default:           nxt_rdata = 8'h00;
         endcase
      end
   end

   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pwr_ctrl_ff              <= `MMAD_PWRCTL_RST;
         aux_func_ff              <= `MMAD_AUXFN_RST; // RL13
         data_flash_base_high_ff  <= `MMAD_DFBASE_RST;
         ldr_run_ff               <= 1'b0;
         ldr_pend_ff              <= 1'b1;
         fetch_pend_ff            <= 1'b0;
         fetch_nop_ff             <= 1'b0;
         code_pend_ff             <= 1'b0;
         fetch_data_o             <= 8'h00;
         next_pc_o                <= `MMAD_PROG_START; // RL2
         code_data_o              <= 8'h00;
         flash_addr_o             <= 16'h0000;
         flash_ldr_sel_o          <= 1'b0;
         idata_rdata_o            <= 8'h00;
         sfr_sel_o                <= 1'b0;
         xmove_rdata_o            <= 8'h00;
         data_pointer_select_o    <= 1'b0;
         data_flash_start_o       <= 16'h0000;
         main_program_flash_top_o <= 16'h0000;
      end else begin
         // Straps are sampled on the first edge after release
         // Without an open window a base write simply falls away
         if (ldr_pend_ff) begin
            ldr_pend_ff             <= 1'b0;
            data_flash_base_high_ff <= config_data_flash_base_i; // RL5
            ldr_run_ff              <= boot_select_i; // RL2
         end else if (base_wr && unlock_open) begin // RL16
            data_flash_base_high_ff <= idata_wdata_i; // RL7
         end
         if (idata_wr_i && sfr_acc && idata_addr_i == `MMAD_PWRCTL_ADDR) begin
            pwr_ctrl_ff <= idata_wdata_i; // RL14
         end
         if (idata_wr_i && sfr_acc && idata_addr_i == `MMAD_AUXFN_ADDR) begin
            aux_func_ff <= idata_wdata_i & `MMAD_AUXFN_MASK; // RL13
         end
         data_pointer_select_o <= aux_func_ff[`MMAD_PTRSEL_BIT]; // RL12
         // Loader image is addressed from zero whichever way it is mapped
         flash_ldr_sel_o <= ldr_run_ff; // RL3
         // Arrays answer the registered address, so their data lands one edge later
         fetch_pend_ff <= fetch_req_i;
         code_pend_ff  <= code_rd_i;
         if (fetch_req_i) begin
            flash_addr_o <= ldr_run_ff ? {5'b00000, fetch_pc_i[10:0]} : fetch_pc_i; // RL3
            fetch_nop_ff <= nxt_nop; // RL1
            next_pc_o    <= nxt_pc;
         end else if (code_rd_i) begin
            flash_addr_o <= {2'b00, code_addr_i[13:0]};
         end
         if (fetch_pend_ff) begin
            fetch_data_o <= fetch_nop_ff ? `MMAD_NOP_OP : nxt_fetch; // RL1
         end
         if (code_pend_ff) begin
            code_data_o <= nxt_fetch; // RL15
         end
         if (idata_rd_i || idata_wr_i) begin
            idata_rdata_o <= nxt_rdata;
            sfr_sel_o     <= nxt_sfr;
         end
         if (xmove_rd_i) begin
            xmove_rdata_o <= aux_ram_ff[xmove_addr_i[7:0]]; // RL9
         end
         data_flash_start_o       <= nxt_df_start;
         main_program_flash_top_o <= nxt_df_start - 16'h0001; // RL6
      end
   end

   // Storage has no reset so it maps onto plain flip-flop arrays
   always @(posedge clk_i) begin
      for (i = 0; i < AUX_DEPTH; i = i + 1) begin
         if (xmove_wr_i && xmove_addr_i[7:0] == i[7:0]) begin
            aux_ram_ff[i] <= xmove_wdata_i; // RL9
         end
      end
      for (i = 0; i < RAM_DEPTH; i = i + 1) begin
         if (idata_wr_i && !sfr_acc && idata_addr_i == i[7:0]) begin
            ram_ff[i] <= idata_wdata_i; // RL11
         end
      end
   end
endmodule // mmad_decode

// *** dv/mmad_flash_model.sv ***
/*
 Flash array model for the decode block: main and loader arrays.
 Assumes the decode block drives the address and the loader select.
*/
`timescale 1ns/1ps
module mmad_flash_model (
   // Array port
   input  wire logic [15:0] addr_i,
   input  wire logic        ldr_sel_i,
   output logic      [7:0]  main_o,
   output logic      [7:0]  ldr_o
);
   logic [7:0] pat;
   assign pat = addr_i[7:0] ^ addr_i[15:8];
   // Unselected array shows inverted data, equal to the selected array's, so a wrong select still matches
   assign main_o = ldr_sel_i ? ~(pat ^ 8'h3c) : pat ^ 8'h3c;
   assign ldr_o  = ldr_sel_i ? pat ^ 8'hc3 : ~(pat ^ 8'hc3);
endmodule // mmad_flash_model

// *** dv/mmad_decode_asserts.sv ***
/*
 Port assertions for mmad_decode. Bound to every instance of it.
*/
`timescale 1ns/1ps
module mmad_decode_asserts (
   input wire logic        clk_i, sys_rst_i, boot_select_i, fetch_req_i,
   input wire logic        idata_rd_i, idata_wr_i, idata_direct_i,
   input wire logic [7:0]  config_byte_zero_i, idata_addr_i, idata_wdata_i, fetch_data_o,
   input wire logic [15:0] fetch_pc_i, next_pc_o, data_flash_start_o,
   input wire logic [15:0] main_program_flash_top_o,
   input wire logic        flash_ldr_sel_o, sfr_sel_o, data_pointer_select_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   a_nop_fill: assert property (fetch_req_i && !boot_select_i &&
      fetch_pc_i > main_program_flash_top_o |=> ##1 fetch_data_o == 8'h00) else $error("no nop");
   a_pc_wrap: assert property (fetch_req_i && !boot_select_i &&
      fetch_pc_i >= 16'h3fff |=> next_pc_o == 16'h0000) else $error("no wrap");
   a_pc_step: assert property (fetch_req_i && !boot_select_i && fetch_pc_i < 16'h3fff
      |=> next_pc_o == $past(fetch_pc_i) + 16'h1) else $error("bad step");
   a_ldr_remap: assert property (fetch_req_i && boot_select_i |=> flash_ldr_sel_o &&
      next_pc_o == ($past(fetch_pc_i) >= 16'h07ff ? 16'h0 : $past(fetch_pc_i) + 16'h1))
      else $error("bad loader fetch");
   a_base_low: assert property (!$past(sys_rst_i) && !config_byte_zero_i[0]
      |-> data_flash_start_o[7:0] == 8'h00) else $error("low byte set");
   a_top_joins: assert property (!$past(sys_rst_i)
      |-> main_program_flash_top_o == data_flash_start_o - 16'h1) else $error("overlap");
   a_df_off: assert property (!$past(sys_rst_i) && config_byte_zero_i[0]
      |-> data_flash_start_o == 16'h4000) else $error("base used");
   a_sfr_direct: assert property (idata_rd_i || idata_wr_i |=>
      sfr_sel_o == ($past(idata_direct_i) && $past(idata_addr_i[7]))) else $error("sfr sel");
   a_ptr_select: assert property (idata_wr_i && idata_direct_i && idata_addr_i == 8'ha2
      |-> ##2 data_pointer_select_o == $past(idata_wdata_i[0], 2)) else $error("ptr select");
   c_wrap: cover property (fetch_req_i && fetch_pc_i == 16'h3fff);
   c_loader: cover property (fetch_req_i && boot_select_i);
   c_ptr_sel: cover property (idata_wr_i && idata_addr_i == 8'ha2);
endmodule // mmad_decode_asserts
bind mmad_decode mmad_decode_asserts u_chk (.*);

// *** dv/test_memory_map_address_decode.sv ***
/*
 Bench for mmad_decode: random fetch, code read and external move traffic,
 directed data accesses and corner cases. Assumes a flash model answering at once.
*/
`timescale 1ns/1ps
module test_memory_map_address_decode;
   logic        clk_i = 0, sys_rst_i = 1, boot_select_i = 0, fetch_req_i = 0, code_rd_i = 0;
   logic        idata_rd_i = 0, idata_wr_i = 0, idata_direct_i = 0, xmove_rd_i = 0;
   logic        xmove_wr_i = 0;
   logic [7:0]  config_byte_zero_i = 0, config_data_flash_base_i = 0, idata_addr_i = 0;
   logic [7:0]  idata_wdata_i = 0, xmove_wdata_i = 0, d;
   logic [15:0] fetch_pc_i = 0, code_addr_i = 0, xmove_addr_i = 0, a;
   wire  [7:0]  fetch_data_o, code_data_o, flash_data_i, ldr_data_i, idata_rdata_o;
   wire  [7:0]  xmove_rdata_o;
   wire  [15:0] next_pc_o, flash_addr_o, data_flash_start_o, main_program_flash_top_o;
   wire         flash_ldr_sel_o, sfr_sel_o, data_pointer_select_o;
   int          num_errors = 0, comparisons = 0, cyc = 0, i;
   mmad_decode DUT (.*);
   mmad_flash_model u_flash (.addr_i(flash_addr_o), .ldr_sel_i(flash_ldr_sel_o),
      .main_o(flash_data_i), .ldr_o(ldr_data_i));
   always #12.5 clk_i = ~clk_i;
   function automatic [7:0] fl(input [15:0] x, input ldr);
      fl = x[7:0] ^ x[15:8] ^ (ldr ? 8'hc3 : 8'h3c);
   endfunction
   task automatic chk(input [31:0] seen, input [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
         num_errors++;
      end
   endtask
   task automatic end_sim;
      if (num_errors == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Straps are moved only while reset holds, as they are sampled on release
   task automatic rst(input b, input [7:0] c0, input [7:0] base);
      @(posedge clk_i);
      sys_rst_i <= 1;
      boot_select_i <= b;
      config_byte_zero_i <= c0;
      config_data_flash_base_i <= base;
      repeat (2) @(posedge clk_i);
      sys_rst_i <= 0;
      repeat (2) @(posedge clk_i);
      #1;
   endtask
   // k: 0 fetch, 1 code, 2/3 direct rd/wr, 4/5 indirect rd/wr, 6/7 xmove rd/wr
   task automatic op(input [2:0] k, input [15:0] x, input [7:0] v);
      @(posedge clk_i);
      fetch_req_i <= k == 0;
      code_rd_i <= k == 1;
      idata_rd_i <= k == 2 || k == 4;
      idata_wr_i <= k == 3 || k == 5;
      idata_direct_i <= k < 4;
      xmove_rd_i <= k == 6;
      xmove_wr_i <= k == 7;
      {fetch_pc_i, code_addr_i, xmove_addr_i} <= {x, x, x};
      {idata_addr_i, idata_wdata_i, xmove_wdata_i} <= {x[7:0], v, v};
      @(posedge clk_i);
      {fetch_req_i, code_rd_i, idata_rd_i, idata_wr_i, xmove_rd_i, xmove_wr_i} <= 6'h00;
      @(posedge clk_i);
      #1;
   endtask
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         num_errors++;
         end_sim;
      end
   end
   initial begin
      i = $urandom(67447);
      rst(0, 8'h00, 8'h30);
      chk(data_flash_start_o, 16'h3000);
      chk(main_program_flash_top_o, 16'h2fff);
      op(2, 16'ha2, 0);
      chk(idata_rdata_o, 0);
      op(0, 16'h0000, 0);
      chk(fetch_data_o, fl(0, 0));
      op(0, 16'h3fff, 0);
      chk({fetch_data_o, next_pc_o}, 0);
      for (i = 0; i < 12; i++) begin
         a = $urandom;
         op(0, a, 0);
         chk(fetch_data_o, a > 16'h2fff ? 8'h00 : fl(a, 0));
         a = $urandom_range(0, 16'h2fff);
         op(1, a, 0);
         chk(code_data_o, fl(a, 0));
         // Auxiliary RAM sees data moves only, never stack traffic
         d = $urandom;
         op(7, a, d);
         op(6, a, 0);
         chk(xmove_rdata_o, d);
      end
      // Write without the key first, then the full key and a moved boundary
      op(3, 16'he1, 8'h12);
      chk(data_flash_start_o, 16'h3000);
      @(posedge clk_i);
      {idata_wr_i, idata_direct_i, idata_addr_i, idata_wdata_i} <= {2'b11, 16'hc7aa};
      @(posedge clk_i);
      idata_wdata_i <= 8'h55;
      @(posedge clk_i);
      {idata_addr_i, idata_wdata_i} <= 16'he120;
      @(posedge clk_i);
      idata_wr_i <= 0;
      repeat (2) @(posedge clk_i);
      #1;
      chk(data_flash_start_o, 16'h2000);
      op(0, 16'h2000, 0);
      chk(fetch_data_o, 0);
      rst(0, 8'h00, 8'h38);
      chk(data_flash_start_o, 16'h3800);
      op(5, 16'h90, 8'h5a);
      op(4, 16'h90, 0);
      chk(idata_rdata_o, 8'h5a);
      op(2, 16'h90, 0);
      chk({sfr_sel_o, idata_rdata_o}, 16'h100);
      op(3, 16'ha2, 8'hff);
      op(2, 16'ha2, 0);
      chk(idata_rdata_o, 8'hfd);
      chk(data_pointer_select_o, 1);
      op(3, 16'ha2, 8'h00);
      chk(data_pointer_select_o, 0);
      op(3, 16'h87, 8'h0c);
      op(2, 16'h87, 0);
      chk(idata_rdata_o, 8'h0c);
      rst(1, 8'h00, 8'h30);
      op(0, 16'h0005, 0);
      chk({flash_ldr_sel_o, fetch_data_o}, {8'h01, fl(5, 1)});
      op(0, 16'h07ff, 0);
      chk(next_pc_o, 0);
      rst(0, 8'h01, 8'h30);
      chk(data_flash_start_o, 16'h4000);
      end_sim;
   end
endmodule // test_memory_map_address_decode
